// *** logic/dpm_pkg.sv ***
/*
  package for the diagnostic probe pin mux: field widths, selector layout,
  pin buffer modes and reset values.
  assumes nothing of its surroundings.
*/
package dpm_pkg;
  // -------------------------------------------------------------
  // widths and layout
  // -------------------------------------------------------------
  localparam int NODE_W = 16;       // internal nodes that may be probed
  localparam int SEL_W = 4;         // bits to pick one node
  localparam int SHIFT_W = 2 * SEL_W + 1; // lock bit, second sel, first sel
  localparam int LOCK_POS = 2 * SEL_W;
  localparam int GPIO_W = 4;        // general i/o pins
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 9'h000;
  // shift frames are only taken with all bits of a full frame counted
  localparam logic [3:0] FRAME_LEN = 4'h9;
  localparam logic [3:0] CNT_RST = 4'h0;

  // i/o buffer configuration per pin
  typedef enum logic [1:0] {
    DPM_IO_IN = 2'h0,
    DPM_IO_OUT = 2'h1,
    DPM_IO_TRI = 2'h2,
    DPM_IO_BIDIR = 2'h3
  } dpm_iomode_t;

  // one pin as output value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } dpm_pin_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0] diag_clock_in_sync;   // two sync stages plus edge history
    logic [1:0] sdi_sync;
    logic [1:0] mode_sync;
    logic [SHIFT_W-1:0] shift;
    logic [3:0] cnt;
    logic [SEL_W-1:0] sel_first;
    logic [SEL_W-1:0] sel_second;
    logic locked;            // probe disabled until reset
    logic probe_first;
    logic probe_second;
  } dpm_state_t;
endpackage

// *** logic/dpm_probe_mux.sv ***
/*
  diagnostic probe pin mux: multifunction pins, probe selection shift
  register, probe lock held until reset, global clock pin and general i/o buffers.
  assumes pin inputs are asynchronous to clk; pads are resolved outside.
*/
// Notes on behaviour
// - mode high: pins take diagnostic functions
// - mode low: pins are plain user i/o
// - diagnostic clock accepted only in mode high
// - serial data honoured only in mode high
// - two independent real-time probe outputs
// - probe lock holds once set, until reset
// - global clock buffered, or used as i/o
// - i/o is input, output, tristate, bidir
// - unused i/o pins driven low
`timescale 1ns/1ps
module dpm_probe_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode and multifunction pins, asynchronous
  input wire logic mode_in,
  input wire logic diag_clock_in,
  input wire logic serial_diag_in,
  // user side of the multifunction pins
  input wire logic [3:0] mf_user_o,
  input wire logic [3:0] mf_user_oe,
  // internal nodes to observe
  input wire logic [dpm_pkg::NODE_W-1:0] nodes,
  // global clock pin and its use
  input wire logic gclk_pin,
  input wire logic gclk_as_io,
  output logic gclk_buf,
  output logic gclk_io_in,
  // probe pins
  output dpm_pkg::dpm_pin_t probe_out_first,
  output dpm_pkg::dpm_pin_t probe_out_second,
  // general i/o
  input wire dpm_pkg::dpm_iomode_t [dpm_pkg::GPIO_W-1:0] io_mode,
  input wire logic [dpm_pkg::GPIO_W-1:0] io_used,
  input wire logic [dpm_pkg::GPIO_W-1:0] io_user_o,
  input wire logic [dpm_pkg::GPIO_W-1:0] io_user_oe,
  input wire logic [dpm_pkg::GPIO_W-1:0] io_pad_i,
  output logic [dpm_pkg::GPIO_W-1:0] io_pad_o,
  output logic [dpm_pkg::GPIO_W-1:0] io_pad_oe,
  output logic [dpm_pkg::GPIO_W-1:0] io_user_i,
  // status
  output logic diag_mode,
  output logic probe_locked
);
  dpm_pkg::dpm_state_t s_r;
  dpm_pkg::dpm_state_t s_nxt;
  logic diag_clock_in_rise;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  // the diagnostic clock is only a sampled pin here: the third stage holds the
  // previous settled level, so a rise is seen once, two to three clocks late;
  // the equipment must hold each level for at least three clock periods
  assign diag_clock_in_rise = s_r.diag_clock_in_sync[1] & ~s_r.diag_clock_in_sync[2];

  // sync pins, shift in bits, load selectors, drive probes
  always_comb begin
    s_nxt = s_r;
    s_nxt.diag_clock_in_sync = {s_r.diag_clock_in_sync[1:0], diag_clock_in};
    s_nxt.sdi_sync = {s_r.sdi_sync[0], serial_diag_in};
    s_nxt.mode_sync = {s_r.mode_sync[0], mode_in};
    // a mode drop throws away any half-shifted frame, so stray bits from user
    // traffic on the data pin can never complete a frame later
    if (!s_r.mode_sync[1]) begin
      s_nxt.cnt = dpm_pkg::CNT_RST; // partial frames dropped
    end else if (diag_clock_in_rise) begin
      s_nxt.shift = {s_r.shift[dpm_pkg::SHIFT_W-2:0], s_r.sdi_sync[1]};
      if (s_r.cnt == dpm_pkg::FRAME_LEN - 4'h1) begin
        s_nxt.cnt = dpm_pkg::CNT_RST;
        s_nxt.sel_first = s_nxt.shift[dpm_pkg::SEL_W-1:0];
        s_nxt.sel_second = s_nxt.shift[2*dpm_pkg::SEL_W-1:dpm_pkg::SEL_W];
        s_nxt.locked = s_r.locked | s_nxt.shift[dpm_pkg::LOCK_POS];
      end else begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
    end
    // probes are registered so the pins never glitch on a selector change;
    // the lock masks the node before the flop, so a locked pin stays low
    s_nxt.probe_first = nodes[s_r.sel_first] & ~s_r.locked;
    s_nxt.probe_second = nodes[s_r.sel_second] & ~s_r.locked;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  // one register for the whole state; reset clears lock and selectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------
  // pins
  // -------------------------------------------------------------
  assign diag_mode = s_r.mode_sync[1];
  assign probe_locked = s_r.locked;

  // probe pins: probe in mode high, user i/o in mode low
  always_comb begin
    if (s_r.mode_sync[1]) begin
      probe_out_first = '{o: s_r.probe_first, oe: 1'b1};
      probe_out_second = '{o: s_r.probe_second, oe: 1'b1};
    end else begin
      probe_out_first = '{o: mf_user_o[0], oe: mf_user_oe[0]};
      probe_out_second = '{o: mf_user_o[1], oe: mf_user_oe[1]};
    end
  end

  // global clock buffer or plain input
  assign gclk_buf = gclk_pin & ~gclk_as_io;
  assign gclk_io_in = gclk_pin & gclk_as_io;

  // general i/o buffers per pin
  // an unused pin is driven low so a floating pad cannot draw current
  for (genvar i = 0; i < dpm_pkg::GPIO_W; i++) begin : g_io
    always_comb begin
      io_pad_o[i] = 1'b0;
      io_pad_oe[i] = 1'b1; // unused pins held low
      io_user_i[i] = 1'b0;
      if (io_used[i]) begin
        unique case (io_mode[i])
          dpm_pkg::DPM_IO_IN: begin
            io_pad_oe[i] = 1'b0;
            io_user_i[i] = io_pad_i[i];
          end
          dpm_pkg::DPM_IO_OUT: begin
            io_pad_o[i] = io_user_o[i];
          end
          dpm_pkg::DPM_IO_TRI: begin
            io_pad_o[i] = io_user_o[i];
            io_pad_oe[i] = io_user_oe[i];
          end
          dpm_pkg::DPM_IO_BIDIR: begin
            io_pad_o[i] = io_user_o[i];
            io_pad_oe[i] = io_user_oe[i];
            io_user_i[i] = io_pad_i[i];
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // probe lock, probe value, shift register and unused pin checks
  chk_lock_sticky: assert property (@(posedge clk) disable iff (rst)
    s_r.locked |=> s_r.locked) else $error("probe lock cleared");
  chk_locked_quiet: assert property (@(posedge clk) disable iff (rst)
    s_r.locked && $past(s_r.locked) && diag_mode |-> !probe_out_first.o && !probe_out_second.o)
    else $error("locked probe exposes node");
  chk_probe_follow: assert property (@(posedge clk) disable iff (rst)
    !s_r.locked && diag_mode |=> !diag_mode || s_r.locked ||
      probe_out_second.o == $past(nodes[s_r.sel_second]))
    else $error("second probe not following node");
  chk_first_follow: assert property (@(posedge clk) disable iff (rst)
    !s_r.locked && diag_mode |=> !diag_mode || s_r.locked ||
      probe_out_first.o == $past(nodes[s_r.sel_first]))
    else $error("first probe not following node");
  chk_user_mode: assert property (@(posedge clk) disable iff (rst)
    !diag_mode |-> probe_out_first.o == mf_user_o[0] && probe_out_first.oe == mf_user_oe[0])
    else $error("probe pin not user i/o in mode low");
  chk_diag_drive: assert property (@(posedge clk) disable iff (rst)
    diag_mode |-> probe_out_first.oe && probe_out_second.oe) else $error("probe not driven");
  chk_no_shift_low: assert property (@(posedge clk) disable iff (rst)
    !diag_mode |=> $stable(s_r.shift) && $stable(s_r.sel_first)) else $error("shift in mode low");
  chk_frame_load: assert property (@(posedge clk) disable iff (rst)
    diag_mode && diag_clock_in_rise && s_r.cnt == dpm_pkg::FRAME_LEN - 4'h1
    |=> s_r.sel_first == $past({s_r.shift[dpm_pkg::SEL_W-2:0], s_r.sdi_sync[1]}))
    else $error("selector not loaded at frame end");
  chk_unused_low: assert property (@(posedge clk) disable iff (rst)
    !io_used[0] |-> io_pad_oe[0] && !io_pad_o[0]) else $error("unused pin not low");
  cov_frame: cover property (@(posedge clk) disable iff (rst)
    diag_mode && diag_clock_in_rise && s_r.cnt == 4'h8);
  cov_lock: cover property (@(posedge clk) disable iff (rst) $rose(s_r.locked));
  cov_mode_swap: cover property (@(posedge clk) disable iff (rst) $fell(diag_mode));

  // frame bookkeeping: bit count stays inside a frame, a mode drop clears it,
  // and the last bit loads the second selector and the lock bit
  chk_cnt_range: assert property (@(posedge clk) disable iff (rst)
    s_r.cnt < dpm_pkg::FRAME_LEN) else $error("bit count past frame length");
  chk_low_drops_frame: assert property (@(posedge clk) disable iff (rst)
    !diag_mode |=> s_r.cnt == dpm_pkg::CNT_RST) else $error("partial frame kept in mode low");
  chk_second_load: assert property (@(posedge clk) disable iff (rst)
    diag_mode && diag_clock_in_rise && s_r.cnt == dpm_pkg::FRAME_LEN - 4'h1
    |=> s_r.sel_second == $past(s_r.shift[2*dpm_pkg::SEL_W-2:dpm_pkg::SEL_W-1]))
    else $error("second selector not loaded at frame end");
  chk_lock_load: assert property (@(posedge clk) disable iff (rst)
    diag_mode && diag_clock_in_rise && s_r.cnt == dpm_pkg::FRAME_LEN - 4'h1 &&
      s_r.shift[dpm_pkg::LOCK_POS-1]
    |=> s_r.locked) else $error("lock bit not taken");

  // ordinary pins: global clock routing and per pin buffer modes
  chk_gclk_buffered: assert property (@(posedge clk) disable iff (rst)
    !gclk_as_io |-> gclk_buf == gclk_pin && !gclk_io_in)
    else $error("global clock not buffered");
  chk_gclk_as_io: assert property (@(posedge clk) disable iff (rst)
    gclk_as_io |-> !gclk_buf && gclk_io_in == gclk_pin)
    else $error("global clock pin not plain input");
  chk_input_pin: assert property (@(posedge clk) disable iff (rst)
    io_used[0] && io_mode[0] == dpm_pkg::DPM_IO_IN
    |-> !io_pad_oe[0] && io_user_i[0] == io_pad_i[0])
    else $error("input pin drives pad");
  chk_tri_pin: assert property (@(posedge clk) disable iff (rst)
    io_used[3] && io_mode[3] == dpm_pkg::DPM_IO_TRI
    |-> io_pad_oe[3] == io_user_oe[3] && io_pad_o[3] == io_user_o[3])
    else $error("tristate pin not under user enable");

  // pin use scenarios
  cov_gclk_io: cover property (@(posedge clk) disable iff (rst) gclk_as_io && !gclk_pin);
  cov_tri_pin: cover property (@(posedge clk) disable iff (rst)
    io_used[3] && io_mode[3] == dpm_pkg::DPM_IO_TRI);
endmodule // dpm_probe_mux

// *** testbench/dpm_equip_model.sv ***
/*
  model of the external probe and programming equipment.
  assumes the bench calls its tasks from a process clocked by clk.
*/
`timescale 1ns/1ps
module dpm_equip_model (
  // bench clock
  input wire logic clk,
  // pins toward the device
  output logic mode_in,
  output logic diag_clock_in,
  output logic serial_diag_in
);
  // idle: mode low, diagnostic clock still
  initial begin
    mode_in = 1'b0;
    diag_clock_in = 1'b0;
    serial_diag_in = 1'b0;
  end

  // raise or drop the mode pin
  task automatic set_mode(input logic m);
    @(posedge clk);
    mode_in <= m;
  endtask

  // nine bits msb first, 800 ns per bit, data set before the rise
  task automatic send_frame(input logic [8:0] f);
    for (int i = 8; i >= 0; i--) begin
      @(posedge clk);
      serial_diag_in <= f[i];
      repeat (3) @(posedge clk);
      diag_clock_in <= 1'b1;
      repeat (4) @(posedge clk);
      diag_clock_in <= 1'b0;
    end
    serial_diag_in <= ~f[0]; // released line shows no stale bit
  endtask
endmodule // dpm_equip_model

// *** testbench/tb_diagnostic_probe_pin_mux.sv ***
/*
  bench for the probe pin mux: user mode, probe frames, lock, i/o pins.
  assumes the equipment model drives mode, diagnostic clock and data.
*/
`timescale 1ns/1ps
module tb_diagnostic_probe_pin_mux;
  logic clk, rst, mode_in, diag_clock_in, serial_diag_in, gclk_pin, gclk_as_io;
  logic [3:0] mf_user_o, mf_user_oe, io_used, io_user_o, io_user_oe, io_pad_i;
  logic [15:0] nodes;
  dpm_pkg::dpm_iomode_t [3:0] io_mode;
  logic gclk_buf, gclk_io_in, diag_mode, probe_locked;
  dpm_pkg::dpm_pin_t probe_out_first, probe_out_second;
  logic [3:0] io_pad_o, io_pad_oe, io_user_i;
  int failures, compares;

  dpm_probe_mux dut (.clk, .rst, .mode_in, .diag_clock_in, .serial_diag_in, .mf_user_o,
    .mf_user_oe, .nodes, .gclk_pin, .gclk_as_io, .gclk_buf, .gclk_io_in, .probe_out_first,
    .probe_out_second, .io_mode, .io_used, .io_user_o, .io_user_oe, .io_pad_i, .io_pad_o,
    .io_pad_oe, .io_user_i, .diag_mode, .probe_locked);
  dpm_equip_model eq (.clk, .mode_in, .diag_clock_in, .serial_diag_in);

  // 10 mhz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [4:0] got, input logic [4:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // mode low: pins are user i/o, frames ignored
  task automatic t_user();
    eq.send_frame(9'h0ff);
    settle(4);
    chk(probe_out_first, 5'h02, "first pin user");
    chk(probe_out_second, 5'h01, "second pin user");
    chk({gclk_buf, gclk_io_in}, 5'h02, "gclk buffered");
    chk({io_pad_oe[3], io_pad_o[3], io_user_i[3]}, 5'h04, "unused pin");
    chk({io_pad_oe[2:0], io_pad_o[1], io_user_i[0]}, 5'h1b, "pin modes");
    @(posedge clk);
    gclk_as_io <= 1'b1;
    settle(1);
    chk({gclk_buf, gclk_io_in}, 5'h01, "gclk as io");
    @(posedge clk);
    gclk_pin <= 1'b0;
    io_used <= 4'hf;
    io_mode[3] <= dpm_pkg::DPM_IO_TRI;
    io_pad_i <= 4'h6;
    mf_user_o <= 4'h2;
    settle(1);
    chk({gclk_buf, gclk_io_in}, 5'h00, "gclk io follows pin");
    chk({io_pad_oe[3], io_pad_o[3], io_user_i[3]}, 5'h02, "tristate pin");
    chk(io_user_i, 5'h04, "pad inputs");
    chk({probe_out_first, probe_out_second}, 5'h03, "user drive change");
    $display("done user mode");
  endtask

  // mode high: selectors from frames, live probes
  task automatic t_probe();
    eq.set_mode(1'b1);
    settle(4);
    chk(diag_mode, 5'h01, "diag mode");
    chk(probe_out_first, 5'h03, "sel kept at zero");
    eq.send_frame(9'h0c3);
    repeat (8) @(posedge clk);
    nodes <= 16'h1008;
    settle(2);
    chk(probe_out_first, 5'h03, "first node 3");
    chk(probe_out_second, 5'h03, "second node 12");
    @(posedge clk);
    nodes <= 16'h0008;
    settle(2);
    chk(probe_out_second, 5'h01, "second follows");
    chk(probe_out_first, 5'h03, "first unchanged");
    $display("done probe");
  endtask

  // lock frame then unlock attempt
  task automatic t_lock();
    eq.send_frame(9'h1c3);
    repeat (8) @(posedge clk);
    nodes <= 16'hffff;
    settle(2);
    chk({probe_locked, probe_out_first, probe_out_second}, 5'h15, "locked");
    eq.send_frame(9'h0c3);
    settle(8);
    chk({probe_locked, probe_out_first, probe_out_second}, 5'h15, "stays locked");
    eq.set_mode(1'b0);
    settle(4);
    chk(probe_out_first, 5'h00, "back to user");
    $display("done lock");
  endtask

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // reset then scenarios
  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    gclk_pin = 1'b1;
    gclk_as_io = 1'b0;
    mf_user_o = 4'h1;
    mf_user_oe = 4'h2;
    nodes = 16'h0001;
    io_used = 4'h7;
    io_mode = '{dpm_pkg::DPM_IO_IN, dpm_pkg::DPM_IO_BIDIR, dpm_pkg::DPM_IO_OUT, dpm_pkg::DPM_IO_IN};
    io_user_o = 4'hf;
    io_user_oe = 4'h4;
    io_pad_i = 4'h9;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_user();
    t_probe();
    t_lock();
    summarize();
  end

  // watchdog well beyond the expected run
  initial begin
    #300000;
    failures++;
    summarize();
  end
endmodule // tb_diagnostic_probe_pin_mux
